// *** rtl/owbr_pkg.sv ***
// Shared constants and types of the one-wire brightness receiver.
// Assumes a single core clock at CLK_MHZ; every time below is converted to cycles of it.
package owbr_pkg;

	localparam int CLK_MHZ        = 10;

	// Command word layout
	localparam int FRAME_BITS     = 24;
	localparam int ADDR_MSB       = 23;
	localparam int ADDR_LSB       = 16;
	localparam int ACK_BIT        = 10;
	localparam int BRT_MSB        = 8;
	localparam int BRT_W          = 9;
	localparam logic [7:0] DEV_ADDR = 8'h8F;
	localparam int RATIO          = 2;

	// Sink command levels
	localparam logic [BRT_W-1:0] SINK_FULL = 9'h1FF;
	localparam logic [BRT_W-1:0] SINK_ZERO = 9'h000;
	localparam logic [BRT_W-1:0] BRT_RESET = 9'h000;

	// Times in their own units
	localparam int REPLY_DELAY_NS = 2000;
	localparam int REPLY_PULSE_US = 512;
	localparam int EN_OFF_US      = 2500;
	localparam int PWM_OFF_US     = 20000;
	localparam int DETECT_US      = 1000;
	localparam int BIT_TIMEOUT_US = 400;

	// Least times round up, longest times round down
	function automatic int ns_up(input int ns);
		return (ns * CLK_MHZ + 999) / 1000;
	endfunction

	localparam int REPLY_DELAY_CYC = ns_up(REPLY_DELAY_NS);
	localparam int REPLY_PULSE_CYC = (REPLY_PULSE_US * CLK_MHZ * 1000) / 1000;
	localparam int EN_OFF_CYC      = ns_up(EN_OFF_US * 1000);
	localparam int PWM_OFF_CYC     = ns_up(PWM_OFF_US * 1000);
	localparam int DETECT_CYC      = ns_up(DETECT_US * 1000);
	localparam int BIT_TIMEOUT_CYC = ns_up(BIT_TIMEOUT_US * 1000);

	// Counter widths
	localparam int CNT_W  = 18;
	localparam int BCNT_W = 5;
	localparam int DUTY_W = 12;

	typedef enum logic [2:0] {MD_OFF, MD_DETECT, MD_WIRE, MD_PWM, MD_LATCH} owbr_mode_t;
	typedef enum logic [1:0] {RX_IDLE, RX_BIT, RX_DELAY, RX_REPLY} owbr_rx_t;

	typedef struct packed {
		logic en;
		logic pwm;
		logic uv;
		logic ovp;
		logic open2;
	} owbr_pins_t;

	typedef struct packed {
		owbr_pins_t             s1;
		owbr_pins_t             s2;
		owbr_pins_t             prev;
		owbr_mode_t             mode;
		owbr_rx_t               rx;
		logic [CNT_W-1:0]       lo;
		logic [CNT_W-1:0]       hi;
		logic [BCNT_W-1:0]      nbits;
		logic                   err;
		logic [FRAME_BITS-1:0]  word;
		logic [CNT_W-1:0]       tmr;
		logic [CNT_W-1:0]       en_lo;
		logic [CNT_W-1:0]       pwm_lo;
		logic [CNT_W-1:0]       det;
		logic [DUTY_W-1:0]      win;
		logic [DUTY_W:0]        hi_acc;
		logic [BRT_W-1:0]       brt;
		logic [BRT_W-1:0]       duty;
		logic [BRT_W-1:0]       sink;
		logic                   frame_ok;
		logic                   pull;
	} owbr_state_t;

	localparam owbr_state_t STATE_RESET = '0;

endpackage

// *** rtl/owbr_top.sv ***
// One-wire brightness receiver: decodes self-timed commands on the enable line,
// answers with a pulldown, selects one-wire or duty dimming, handles timeouts and faults.
// Assumes all pins are asynchronous to MCLK; CE comes from MCLK logic.
//
// How it works
// - Word is 24 bits, sent least significant bit first; assemble in that order.
// - If enable is already high, a command starts at the next falling edge.
// - Low at least twice high means zero; high at least twice low means one.
// - A bit cell runs falling edge to falling edge; value decided at closing edge.
// - Reply only with ack request set, address matching and 24 good bits.
// - After the reply delay, pull enable low for the reply pulse, at most 512 us.
// - If one-wire mode is not entered at startup, fall back to duty dimming.
// - Enable tied high: PWM high or pulsing enables, PWM low over 20 ms disables.
// - Shut down if enable low over 2.5 ms or PWM low over 20 ms.
// - Start up only once both enable and PWM are asserted.
// - In duty mode, PWM continuously high commands full-scale sink current.
// - In duty mode the sink command is full scale times measured duty.
// - Stay off during undervoltage; restart once it clears.
// - Switch overvoltage with both strings open latches off until reset or toggle.
// - Switch overvoltage from high string voltage turns switch off and shuts down.
// - Brightness bit 0 is word bit 0; bits 7..1 sit at word bits 7..1.
// - Word bits 23..16 hold the address, which must equal 0x8F.
// - Word bit 10 is the ack request flag.
// - Word bit 8 is the top bit of the 9-bit brightness code.

`timescale 1ns/100ps

module owbr_top
	import owbr_pkg::*;
#(
	parameter int REPLY_PULSE_N = REPLY_PULSE_CYC,
	parameter int EN_OFF_N      = EN_OFF_CYC,
	parameter int PWM_OFF_N     = PWM_OFF_CYC,
	parameter int DETECT_N      = DETECT_CYC
) (
	input  wire logic             MCLK,
	input  wire logic             RESET_N,
	input  wire logic             CE,
	input  wire logic             EN_IN,
	output logic                  EN_PULL_OUT,
	output logic                  EN_PULL_OE,
	input  wire logic             PWM_IN,
	input  wire logic             UVLO,
	input  wire logic             OVP_SW,
	input  wire logic             STRINGS_OPEN,
	output logic                  DEVICE_ON,
	output logic                  SWITCH_EN,
	output logic                  WIRE_MODE,
	output logic                  PWM_MODE,
	output logic                  FAULT_LATCHED,
	output logic                  FRAME_OK,
	output logic [BRT_W-1:0]      BRIGHTNESS,
	output logic [BRT_W-1:0]      SINK_LEVEL
);

	localparam logic [CNT_W-1:0]  PULSE_LAST = CNT_W'(REPLY_PULSE_N - 1);
	localparam logic [CNT_W-1:0]  DELAY_LAST = CNT_W'(REPLY_DELAY_CYC - 1);
	localparam logic [CNT_W-1:0]  EN_OFF_Q   = CNT_W'(EN_OFF_N);
	localparam logic [CNT_W-1:0]  PWM_OFF_Q  = CNT_W'(PWM_OFF_N);
	localparam logic [CNT_W-1:0]  DET_LAST   = CNT_W'(DETECT_N - 1);
	localparam logic [CNT_W-1:0]  BIT_TO     = CNT_W'(BIT_TIMEOUT_CYC);
	localparam logic [BCNT_W-1:0] LAST_BIT   = BCNT_W'(FRAME_BITS - 1);

	owbr_state_t           q;
	owbr_state_t           d;
	owbr_pins_t            pin_i;
	logic                  en_fall;
	logic                  en_tog;
	logic                  pwm_tog;
	logic                  active;
	logic                  wire_ok;
	logic                  bit_zero;
	logic                  bit_one;
	logic                  frame_good;
	logic                  frame_end;
	logic [FRAME_BITS-1:0] nword;
	logic [DUTY_W:0]       acc_n;

	// Saturating so that a stuck line cannot wrap a timeout back to zero
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		return (&v) ? v : v + CNT_W'(1);
	endfunction

	assign pin_i = '{en: EN_IN, pwm: PWM_IN, uv: UVLO, ovp: OVP_SW, open2: STRINGS_OPEN};

	always_comb begin
		d          = q;
		d.frame_ok = 1'b0;
		d.s1       = pin_i;
		d.s2       = q.s1;
		d.prev     = q.s2;
		en_fall    = q.prev.en & ~q.s2.en;
		en_tog     = q.prev.en ^ q.s2.en;
		pwm_tog    = q.prev.pwm ^ q.s2.pwm;
		active     = (q.mode == MD_DETECT) || (q.mode == MD_WIRE) || (q.mode == MD_PWM);
		wire_ok    = (q.mode == MD_DETECT) || (q.mode == MD_WIRE);
		// Phases compared against twice the other, one bit wider to avoid overflow
		bit_zero   = {1'b0, q.lo} >= ({1'b0, q.hi} * (CNT_W+1)'(RATIO));
		bit_one    = {1'b0, q.hi} >= ({1'b0, q.lo} * (CNT_W+1)'(RATIO));
		nword      = {bit_one, q.word[FRAME_BITS-1:1]};
		frame_end  = (q.rx == RX_BIT) && en_fall && (q.nbits == LAST_BIT);
		frame_good = frame_end && !(q.err || !(bit_zero || bit_one))
			&& (nword[ADDR_MSB:ADDR_LSB] == DEV_ADDR);
		acc_n      = q.hi_acc + (DUTY_W+1)'(q.s2.pwm);

		d.en_lo  = q.s2.en ? '0 : sat_inc(q.en_lo);
		d.pwm_lo = q.s2.pwm ? '0 : sat_inc(q.pwm_lo);

		// Bit receiver
		unique case (q.rx)
			RX_IDLE: begin
				if (en_fall && wire_ok) begin
					d.rx    = RX_BIT;
					d.lo    = '0;
					d.hi    = '0;
					d.nbits = '0;
					d.err   = 1'b0;
				end
			end
			RX_BIT: begin
				if (q.s2.en) begin
					d.hi = sat_inc(q.hi);
				end else begin
					d.lo = sat_inc(q.lo);
				end
				if (en_fall) begin
					d.word  = nword;
					d.err   = q.err | !(bit_zero || bit_one);
					d.nbits = q.nbits + BCNT_W'(1);
					d.lo    = '0;
					d.hi    = '0;
					if (frame_end) begin
						d.rx = RX_IDLE;
						if (frame_good) begin
							d.brt      = nword[BRT_MSB:0];
							d.frame_ok = 1'b1;
							if (nword[ACK_BIT]) begin
								d.rx  = RX_DELAY;
								d.tmr = '0;
							end
						end
					end
				end else if (q.lo >= BIT_TO || q.hi >= BIT_TO) begin
					// A stalled cell drops the partial frame; a short count never replies
					d.rx = RX_IDLE;
				end
				if (!wire_ok) begin
					d.rx = RX_IDLE;
				end
			end
			RX_DELAY: begin
				// Host keeps the line low here; edges are not decoded until the pulse ends
				d.tmr = q.tmr + CNT_W'(1);
				if (q.tmr == DELAY_LAST) begin
					d.rx   = RX_REPLY;
					d.tmr  = '0;
					d.pull = 1'b1;
				end
			end
			RX_REPLY: begin
				d.tmr = q.tmr + CNT_W'(1);
				if (q.tmr == PULSE_LAST) begin
					d.rx   = RX_IDLE;
					d.pull = 1'b0;
				end
			end
		endcase

		// Operating mode
		unique case (q.mode)
			MD_OFF: begin
				if (q.s2.en && q.s2.pwm && !q.s2.uv && !q.s2.ovp) begin
					d.mode = MD_DETECT;
					d.det  = '0;
				end
			end
			MD_DETECT: begin
				d.det = sat_inc(q.det);
				if (frame_good) begin
					d.mode = MD_WIRE;
				end else if (q.det >= DET_LAST) begin
					d.mode = MD_PWM;
				end
			end
			MD_WIRE, MD_PWM: begin
			end
			MD_LATCH: begin
				if (en_tog || pwm_tog) begin
					d.mode = MD_OFF;
				end
			end
		endcase
		if (active) begin
			if (q.s2.ovp && q.s2.open2) begin
				d.mode = MD_LATCH;
			end else if (q.s2.uv) begin
				d.mode = MD_OFF;
			end else if (q.s2.ovp) begin
				d.mode = MD_OFF;
			end else if (q.en_lo > EN_OFF_Q || q.pwm_lo > PWM_OFF_Q) begin
				d.mode = MD_OFF;
			end
		end
		if (d.mode != MD_DETECT && d.mode != MD_WIRE && q.rx != RX_IDLE) begin
			d.rx   = RX_IDLE;
			d.pull = 1'b0;
		end

		// Duty measured over a window of 2**DUTY_W samples; all high saturates to full scale
		d.win    = q.win + DUTY_W'(1);
		d.hi_acc = acc_n;
		if (&q.win) begin
			d.duty   = acc_n[DUTY_W] ? SINK_FULL : acc_n[DUTY_W-1 -: BRT_W];
			d.hi_acc = '0;
		end

		unique case (q.mode)
			MD_WIRE: d.sink = q.brt;
			MD_PWM:  d.sink = q.duty;
			default: d.sink = SINK_ZERO;
		endcase
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= STATE_RESET;
		end else if (CE) begin
			q <= d;
		end
	end

	assign EN_PULL_OUT   = 1'b0;
	assign EN_PULL_OE    = q.pull;
	assign DEVICE_ON     = (q.mode == MD_DETECT) || (q.mode == MD_WIRE) || (q.mode == MD_PWM);
	assign SWITCH_EN     = DEVICE_ON && !q.s2.ovp;
	assign WIRE_MODE     = (q.mode == MD_WIRE);
	assign PWM_MODE      = (q.mode == MD_PWM);
	assign FAULT_LATCHED = (q.mode == MD_LATCH);
	assign FRAME_OK      = q.frame_ok;
	assign BRIGHTNESS    = q.brt;
	assign SINK_LEVEL    = q.sink;

	// Checks; a frozen clock enable suspends them
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N || !CE);

	sequence s_cell_close;
		q.rx == RX_BIT && en_fall;
	endsequence

	sequence s_bad_end;
		frame_end && !frame_good;
	endsequence

	AST_LSB_FIRST: assert property (s_cell_close
		|=> q.word[FRAME_BITS-2] == $past(q.word[FRAME_BITS-1]))
		else $error("received bit not shifted toward the low end");
	AST_ZERO_RATIO: assert property (s_cell_close ##0 (q.lo >= 2 * q.hi)
		|=> !q.word[FRAME_BITS-1])
		else $error("long low phase not decoded as zero");
	AST_ONE_RATIO: assert property (s_cell_close ##0 ((q.hi >= 2 * q.lo) && (q.hi > 0))
		|=> q.word[FRAME_BITS-1])
		else $error("long high phase not decoded as one");
	AST_ACK_GATE: assert property ($rose(q.rx == RX_DELAY)
		|-> FRAME_OK && q.word[ACK_BIT] && q.word[ADDR_MSB:ADDR_LSB] == DEV_ADDR)
		else $error("reply armed without a good addressed frame with ack request");
	AST_REPLY_START: assert property ($rose(EN_PULL_OE)
		|-> $past(q.rx == RX_DELAY) && $past(q.tmr) == DELAY_LAST)
		else $error("pulldown not switched on exactly after the reply delay");
	AST_REPLY_LEN: assert property (EN_PULL_OE |-> q.tmr <= PULSE_LAST)
		else $error("reply pulse longer than allowed");
	AST_BAD_SILENT: assert property (s_bad_end
		|=> q.rx == RX_IDLE && !FRAME_OK && $stable(BRIGHTNESS))
		else $error("bad frame changed brightness or armed a reply");
	AST_BRT_CAUSE: assert property ($changed(BRIGHTNESS) |-> FRAME_OK)
		else $error("brightness changed without a good frame");
	AST_START_BOTH: assert property ($rose(DEVICE_ON) |-> $past(q.s2.en && q.s2.pwm))
		else $error("device started without both enable and PWM");
	AST_UV_OFF: assert property (DEVICE_ON && q.s2.uv |=> !DEVICE_ON)
		else $error("device stayed on under undervoltage");
	AST_EN_TIMEOUT: assert property (DEVICE_ON && q.en_lo > EN_OFF_Q |=> !DEVICE_ON)
		else $error("enable low timeout did not shut down");
	AST_LATCH_HOLD: assert property (FAULT_LATCHED && !en_tog && !pwm_tog |=> FAULT_LATCHED)
		else $error("fault latch released without a toggle");
	AST_FULL_SCALE: assert property (PWM_MODE && (&q.win) && acc_n[DUTY_W]
		|=> q.duty == SINK_FULL ##1 (!PWM_MODE || SINK_LEVEL == SINK_FULL))
		else $error("steady high PWM did not give full-scale sink level");

endmodule

// *** verification/owbr_host.sv ***
// Host controller model: open-drain driver on the enable line plus the PWM output.
// Assumes a pull-up on the enable line; drives only on falling clock edges.
`timescale 1ns/100ps
module owbr_host (
	input  wire logic clk,
	input  wire logic line,
	output logic      pull_low,
	output logic      pwm
);
	initial begin
		pull_low = 1'b0;
		pwm      = 1'b0;
	end

	task automatic hold(input logic p, input logic low, input int n);
		pwm = p;
		pull_low = low;
		repeat (n) @(negedge clk);
	endtask

	// Bad cell has equal phases, so neither ratio class applies
	task automatic frame(input logic [23:0] w, input int n, input int bad, input int start,
		output logic seen);
		int i;
		int lo;
		pull_low = 1'b0;
		repeat (start) @(negedge clk);
		for (i = 0; i < n; i++) begin
			lo = w[i] ? 10 : 30;
			if (i == bad) begin
				lo = 20;
			end
			pull_low = 1'b1;
			repeat (lo) @(negedge clk);
			pull_low = 1'b0;
			repeat (40 - lo) @(negedge clk);
		end
		pull_low = 1'b1;
		repeat (25) @(negedge clk);
		pull_low = 1'b0;
		repeat (4) @(negedge clk);
		seen = line;
		for (i = 0; i < 200 && line !== 1'b1; i++) @(negedge clk);
	endtask
endmodule

// *** verification/owbr_top_test.sv ***
// Self-checking bench for the one-wire brightness receiver.
// Assumes the host model owbr_host; long timeouts are shortened by parameters.
`timescale 1ns/100ps
module owbr_top_test;
	import owbr_pkg::*;
	localparam int PULSE_N = 50;
	logic             mclk;
	logic             reset_n;
	logic             uvlo;
	logic             ovp;
	logic             open2;
	logic             host_low;
	logic             pwm;
	logic             line;
	logic             pull_oe;
	logic             pull_out;
	logic             dev_on;
	logic             sw_en;
	logic             wire_m;
	logic             pwm_m;
	logic             fault;
	logic             fok;
	logic [BRT_W-1:0] brt;
	logic [BRT_W-1:0] sink;
	logic             seen;
	logic [7:0]       addrs [3] = '{8'h8E, 8'h8F, 8'h8F};
	int               lens [3]  = '{24, 24, 23};
	int               bads [3]  = '{-1, 5, -1};
	int               fail_count;
	int               check_count;
	int               fok_n;
	int               pcnt;
	int               plen;
	int               i;

	// Pull-up wins unless host or device pulls low
	assign line = ~host_low & (pull_oe ? pull_out : 1'b1);

	owbr_top #(.REPLY_PULSE_N(PULSE_N), .EN_OFF_N(300), .PWM_OFF_N(600), .DETECT_N(2000))
	u_owbr_top (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1), .EN_IN(line),
		.EN_PULL_OUT(pull_out), .EN_PULL_OE(pull_oe), .PWM_IN(pwm), .UVLO(uvlo),
		.OVP_SW(ovp), .STRINGS_OPEN(open2), .DEVICE_ON(dev_on), .SWITCH_EN(sw_en),
		.WIRE_MODE(wire_m), .PWM_MODE(pwm_m), .FAULT_LATCHED(fault), .FRAME_OK(fok),
		.BRIGHTNESS(brt), .SINK_LEVEL(sink));

	owbr_host u_owbr_host (.clk(mclk), .line(line), .pull_low(host_low), .pwm(pwm));

	always #50 mclk = ~mclk;

	always @(posedge mclk) begin
		if (fok === 1'b1) begin
			fok_n <= fok_n + 1;
		end
		if (pull_oe === 1'b1) begin
			pcnt <= pcnt + 1;
		end else if (pcnt != 0) begin
			plen <= pcnt;
			pcnt <= 0;
		end
	end

	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic send(input logic [7:0] a, input logic ack, input logic [8:0] b,
		input int n, input int bad, input int start);
		fok_n = 0;
		plen = 0;
		u_owbr_host.frame({a, 5'h00, ack, 1'b0, b}, n, bad, start, seen);
		repeat (2) @(negedge mclk);
	endtask

	task automatic hold(input logic p, input logic low, input int n);
		u_owbr_host.hold(p, low, n);
	endtask

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Whole run is about 30700 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		print_verdict;
	end

	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		{uvlo, ovp, open2} = 3'h0;
		{fail_count, check_count, fok_n, pcnt, plen} = '0;
		repeat (4) @(negedge mclk);
		reset_n = 1'b1;
		chk("on", 9'h000, dev_on);
		chk("brightness", 9'h000, brt);
		done("reset");
		hold(1'b0, 1'b0, 20);
		chk("on", 9'h000, dev_on);
		hold(1'b1, 1'b0, 10);
		chk("on", 9'h001, dev_on);
		done("startup");
		send(8'h8F, 1'b1, 9'h1A5, 24, -1, 20);
		chk("reply line", 9'h000, seen);
		chk("frame ok", 9'h001, 9'(fok_n));
		chk("pulse", 9'(PULSE_N), 9'(plen));
		chk("brightness", 9'h1A5, brt);
		chk("wire", 9'h001, wire_m);
		chk("sink", 9'h1A5, sink);
		send(8'h8F, 1'b0, 9'h0F3, 24, -1, 0);
		chk("pulse", 9'h000, 9'(plen));
		chk("brightness", 9'h0F3, brt);
		for (i = 0; i < 3; i++) begin
			send(addrs[i], 1'b1, 9'h0AA, lens[i], bads[i], 20);
			repeat (i == 2 ? 4100 : 0) @(negedge mclk);
			chk("reply line", 9'h001, seen);
			chk("frame ok", 9'h000, 9'(fok_n));
			chk("brightness", 9'h0F3, brt);
		end
		send(8'h8F, 1'b0, 9'h155, 24, -1, 20);
		chk("brightness", 9'h155, brt);
		done("frames");
		hold(1'b1, 1'b1, 290);
		chk("on", 9'h001, dev_on);
		hold(1'b1, 1'b1, 30);
		chk("on", 9'h000, dev_on);
		done("enable timeout");
		hold(1'b1, 1'b0, 2100);
		chk("pwm mode", 9'h001, pwm_m);
		hold(1'b1, 1'b0, 8400);
		chk("sink", 9'h1FF, sink);
		for (i = 0; i < 140; i++) begin
			hold(1'b0, 1'b0, 32);
			hold(1'b1, 1'b0, 32);
		end
		chk("sink", 9'h100, sink);
		hold(1'b0, 1'b0, 580);
		chk("on", 9'h001, dev_on);
		hold(1'b0, 1'b0, 40);
		chk("on", 9'h000, dev_on);
		hold(1'b1, 1'b0, 10);
		chk("on", 9'h001, dev_on);
		done("pwm");
		uvlo = 1'b1;
		hold(1'b1, 1'b0, 8);
		chk("on", 9'h000, dev_on);
		uvlo = 1'b0;
		hold(1'b1, 1'b0, 8);
		chk("on", 9'h001, dev_on);
		ovp = 1'b1;
		hold(1'b1, 1'b0, 8);
		chk("switch", 9'h000, sw_en);
		chk("fault", 9'h000, fault);
		ovp = 1'b0;
		hold(1'b1, 1'b0, 8);
		chk("on", 9'h001, dev_on);
		{ovp, open2} = 2'h3;
		hold(1'b1, 1'b0, 8);
		{ovp, open2} = 2'h0;
		hold(1'b1, 1'b0, 20);
		chk("fault", 9'h001, fault);
		chk("on", 9'h000, dev_on);
		hold(1'b0, 1'b0, 8);
		hold(1'b1, 1'b0, 8);
		chk("fault", 9'h000, fault);
		chk("on", 9'h001, dev_on);
		done("protection");
		print_verdict;
	end
endmodule
